// ==== sdp_consts.vh ====
// sdp_consts.vh: shared constants of the simd core datapath
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH

// ============================================================
// instruction word fields (48-bit word)
`define SDP_ALU_OP   47:44
`define SDP_ALU_DST  43:40
`define SDP_ALU_X    39:36
`define SDP_ALU_Y    35:32
`define SDP_MUL_OP   31:30
`define SDP_MUL_DST  29:26
`define SDP_MUL_X    25:22
`define SDP_MUL_Y    21:18
`define SDP_DM_EN    17
`define SDP_DM_WR    16
`define SDP_DM_REG   15:12
`define SDP_DM_PTR   11:9
`define SDP_PM_EN    8
`define SDP_PM_WR    7
`define SDP_PM_REG   6:3
`define SDP_PM_PTR   2:0
`define SDP_NOP      48'h000000000000

// ============================================================
// alu and shifter operation codes
`define SDP_OP_ADD   4'h1
`define SDP_OP_SUB   4'h2
`define SDP_OP_AND   4'h3
`define SDP_OP_OR    4'h4
`define SDP_OP_XOR   4'h5
`define SDP_OP_LSL   4'h6
`define SDP_OP_LSR   4'h7
`define SDP_OP_ASR   4'h8
`define SDP_OP_PACK  4'h9
`define SDP_OP_UNPK  4'ha
// multiplier operation codes
`define SDP_MUL_FIX  2'h1
`define SDP_MUL_FLT  2'h2

// ============================================================
// access sizes: lanes of 16 bits minus one
`define SDP_SZ16     2'h0
`define SDP_SZ32     2'h1
`define SDP_SZ48     2'h2
`define SDP_SZ64     2'h3

// ============================================================
// float format constants
`define SDP_FP_BIAS  10'h07f
`define SDP_H_EMIN   8'h70
`define SDP_H_EMAX   8'h8f

// ============================================================
// pointer set field selectors
`define SDP_PF_IDX   2'h0
`define SDP_PF_MOD   2'h1
`define SDP_PF_BASE  2'h2
`define SDP_PF_LEN   2'h3

`endif

// ==== sdp_pe.v ====
// sdp_pe.v: one processing element with register file and units
`timescale 1ns/1ps
`default_nettype none
`include "sdp_consts.vh"

module sdp_pe (
    input  wire        clock_i,
    input  wire        nrst_i,
    input  wire        active_i,
    input  wire        alt_i,
    input  wire [47:0] instr_i,
    input  wire        dm_ld_i,
    input  wire [3:0]  dm_ld_reg_i,
    input  wire [31:0] dm_ld_data_i,
    input  wire        pm_ld_i,
    input  wire [3:0]  pm_ld_reg_i,
    input  wire [31:0] pm_ld_data_i,
    output wire [31:0] dm_st_data_o,
    output wire [31:0] pm_st_data_o
);

// ============================================================
// helpers
// register address with the primary or alternate half
function [4:0] ra;
    input [3:0] r;
    begin
        ra = {alt_i, r};
    end
endfunction

// 40-bit extended float multiply; single precision is the
// same layout with the low 8 mantissa bits zero
function [39:0] fmul;
    input [39:0] a;
    input [39:0] b;
    reg   [63:0] p;
    reg   [9:0]  e;
    reg          s;
    begin
        s = a[39] ^ b[39];
        p = {32'h0, 1'b1, a[30:0]} * {32'h0, 1'b1, b[30:0]};
        e = {2'b00, a[38:31]} + {2'b00, b[38:31]}
            + {9'h000, p[63]} - `SDP_FP_BIAS;
        if (a[38:31] == 8'h00 || b[38:31] == 8'h00 || e[9]
            || e == 10'h000)
            fmul = {s, 39'h0};
        else if (e >= 10'h0ff)
            fmul = {s, 8'hff, 31'h0};
        else if (p[63])
            fmul = {s, e[7:0], p[62:32]};
        else
            fmul = {s, e[7:0], p[61:31]};
    end
endfunction

// 32-bit float to packed 16-bit float, saturating
function [15:0] pack16;
    input [31:0] f;
    reg   [7:0]  e;
    begin
        e = f[30:23] - `SDP_H_EMIN;
        if (f[30:23] <= `SDP_H_EMIN)
            pack16 = {f[31], 15'h0000};
        else if (f[30:23] >= `SDP_H_EMAX)
            pack16 = {f[31], 5'h1f, 10'h000};
        else
            pack16 = {f[31], e[4:0], f[22:13]};
    end
endfunction

// packed 16-bit float back to 32-bit float
function [31:0] unpk16;
    input [15:0] h;
    begin
        if (h[14:10] == 5'h00)
            unpk16 = {h[15], 31'h0};
        else
            unpk16 = {h[15], {3'b000, h[14:10]} + `SDP_H_EMIN,
                      h[9:0], 13'h0000};
    end
endfunction

// ============================================================
// register file: 16 primary plus 16 alternate, 6 reads 4 writes
reg  [39:0] rf_reg [0:31];
wire [31:0] ax = rf_reg[ra(instr_i[`SDP_ALU_X])][39:8];
wire [31:0] ay = rf_reg[ra(instr_i[`SDP_ALU_Y])][39:8];
wire [39:0] mx = rf_reg[ra(instr_i[`SDP_MUL_X])];
wire [39:0] my = rf_reg[ra(instr_i[`SDP_MUL_Y])];
assign dm_st_data_o = rf_reg[ra(instr_i[`SDP_DM_REG])][39:8];
assign pm_st_data_o = rf_reg[ra(instr_i[`SDP_PM_REG])][39:8];

reg  [39:0] alu_res;
reg         alu_we;
reg  [39:0] mul_res;
reg         mul_we;
reg  [63:0] prod;
integer     i;

// alu and shifter: fixed point sits in the upper 32 bits
always @* begin
    alu_res = 40'h0;
    alu_we  = active_i;
    case (instr_i[`SDP_ALU_OP])
    `SDP_OP_ADD:  alu_res = {ax + ay, 8'h00};
    `SDP_OP_SUB:  alu_res = {ax - ay, 8'h00};
    `SDP_OP_AND:  alu_res = {ax & ay, 8'h00};
    `SDP_OP_OR:   alu_res = {ax | ay, 8'h00};
    `SDP_OP_XOR:  alu_res = {ax ^ ay, 8'h00};
    `SDP_OP_LSL:  alu_res = {ax << ay[4:0], 8'h00};
    `SDP_OP_LSR:  alu_res = {ax >> ay[4:0], 8'h00};
    `SDP_OP_ASR:  alu_res = {$signed(ax) >>> ay[4:0], 8'h00};
    `SDP_OP_PACK: alu_res = {16'h0000, pack16(ax), 8'h00};
    `SDP_OP_UNPK: alu_res = {unpk16(ax[15:0]), 8'h00};
    default:      alu_we  = 1'b0;
    endcase
end

// multiplier runs beside the alu in the same cycle
always @* begin
    prod    = {32'h0, mx[39:8]} * {32'h0, my[39:8]};
    mul_res = 40'h0;
    mul_we  = active_i;
    case (instr_i[`SDP_MUL_OP])
    `SDP_MUL_FIX: mul_res = {prod[31:0], 8'h00};
    `SDP_MUL_FLT: mul_res = fmul(mx, my);
    default:      mul_we  = 1'b0;
    endcase
end

// write ports; loads land last so a bus value wins a clash
always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        for (i = 0; i < 32; i = i + 1)
            rf_reg[i] <= 40'h0;
    end else begin
        if (mul_we)
            rf_reg[ra(instr_i[`SDP_MUL_DST])] <= mul_res;
        if (alu_we)
            rf_reg[ra(instr_i[`SDP_ALU_DST])] <= alu_res;
        if (dm_ld_i & active_i)
            rf_reg[ra(dm_ld_reg_i)] <= {dm_ld_data_i, 8'h00};
        if (pm_ld_i & active_i)
            rf_reg[ra(pm_ld_reg_i)] <= {pm_ld_data_i, 8'h00};
    end
end

endmodule // sdp_pe
`default_nettype wire

// ==== sdp_core.v ====
// sdp_core.v: simd core datapath with dual-ported memory blocks
`timescale 1ns/1ps
`default_nettype none
`include "sdp_consts.vh"

module sdp_core #(
    parameter BLK_AW = 16,
    parameter CAW    = 5
) (
    input  wire              clock_i,
    input  wire              nrst_i,
    input  wire              second_element_enable_i,
    input  wire              alt_regs_i,
    input  wire              alt_ptrs_i,
    input  wire              fetch_req_i,
    input  wire [BLK_AW:0]   fetch_addr_i,
    output wire              fetch_ready_o,
    output wire              exec_hold_o,
    output wire              cache_hit_o,
    output wire [47:0]       instr_o,
    input  wire              ptr_wr_i,
    input  wire [4:0]        ptr_set_i,
    input  wire [1:0]        ptr_field_i,
    input  wire [BLK_AW:0]   ptr_data_i,
    input  wire              io_req_i,
    input  wire              io_we_i,
    input  wire [BLK_AW:0]   io_addr_i,
    input  wire [1:0]        io_size_i,
    input  wire [63:0]       io_wdata_i,
    output reg  [63:0]       io_rdata_o,
    output reg               io_rvalid_o
);

// ============================================================
// local constants and helpers
localparam ISRC_NOP   = 3'b001;
localparam ISRC_MEM   = 3'b010;
localparam ISRC_CACHE = 3'b100;
localparam NLINE      = 1 << CAW;
localparam BDEPTH     = 1 << BLK_AW;

// pointer set: alternate half, generator, pointer
function [4:0] pset;
    input       address_generator;
    input [2:0] p;
    begin
        pset = {alt_ptrs_i, address_generator, p};
    end
endfunction

// halfword offset of lane k inside a block
function [BLK_AW-1:0] hadd;
    input [BLK_AW-1:0] a;
    input [1:0]        k;
    begin
        hadd = a + {{(BLK_AW-2){1'b0}}, k};
    end
endfunction

// post-modify with wrap; a zero length means linear addressing
function [BLK_AW:0] circ;
    input [BLK_AW:0] i;
    input [BLK_AW:0] m;
    input [BLK_AW:0] b;
    input [BLK_AW:0] l;
    reg   [BLK_AW+1:0] s;
    reg   [BLK_AW+1:0] e;
    begin
        s    = {1'b0, i} + {m[BLK_AW], m};
        e    = {1'b0, b} + {1'b0, l};
        circ = s[BLK_AW:0];
        if (l != {(BLK_AW+1){1'b0}}) begin
            if (!m[BLK_AW] && s >= e)
                circ = s[BLK_AW:0] - l;
            else if (m[BLK_AW] && (s[BLK_AW+1] || s < {1'b0, b}))
                circ = s[BLK_AW:0] + l;
        end
    end
endfunction

// ============================================================
// storage
// two blocks of halfwords; any word size packs into lanes
reg  [15:0]       mem [0:1][0:BDEPTH-1];
reg  [BLK_AW:0]   idx_reg  [0:31];
reg  [BLK_AW:0]   mod_reg  [0:31];
reg  [BLK_AW:0]   base_reg [0:31];
reg  [BLK_AW:0]   len_reg  [0:31];
reg  [47:0]       ic_data_reg [0:NLINE-1];
reg  [BLK_AW-CAW:0] ic_tag_reg [0:NLINE-1];
reg  [NLINE-1:0]  ic_vld_reg;
reg  [47:0]       imem_reg;
reg  [47:0]       icache_reg;
reg  [2:0]        isrc_reg;
reg               phase_reg;
reg               alloc_pend_reg;
reg               alloc_now_reg;
reg  [BLK_AW:0]   alloc_addr_reg;
reg  [63:0]       dm_rdata_reg;
reg  [63:0]       pm_rdata_reg;
reg               dm_ldv_reg;
reg               pm_ldv_reg;
reg  [3:0]        dm_ldr_reg;
reg  [3:0]        pm_ldr_reg;
integer           k;
integer           n;
integer           lane;

// ============================================================
// issue and bus steering
wire [47:0] instr = (isrc_reg == ISRC_MEM)   ? imem_reg :
                    (isrc_reg == ISRC_CACHE) ? icache_reg :
                    `SDP_NOP;
wire        simd  = second_element_enable_i;
// simd doubles each access so both elements get a value
wire [1:0]  csz   = simd ? `SDP_SZ64 : `SDP_SZ32;
wire [4:0]  dset  = pset(1'b0, instr[`SDP_DM_PTR]);
wire [4:0]  pset2 = pset(1'b1, instr[`SDP_PM_PTR]);
wire [BLK_AW:0] dm_addr  = idx_reg[dset];
wire [BLK_AW:0] pmd_addr = idx_reg[pset2];
wire        dm_act  = instr[`SDP_DM_EN] & ~phase_reg;
wire        pmd_act = instr[`SDP_PM_EN];
wire [CAW-1:0] line = fetch_addr_i[CAW-1:0];
wire        ic_hit  = ic_vld_reg[line] &
                      (ic_tag_reg[line] == fetch_addr_i[BLK_AW:CAW]);
// fetches use the program bus only when it carries no data
wire        fetch_mem = fetch_req_i & ~pmd_act;
wire        pm_act  = pmd_act | fetch_mem;
wire [BLK_AW:0] pm_addr = pmd_act ? pmd_addr : fetch_addr_i;
// both core buses on one block: the core port serves data
// first and the program-bus half waits one cycle
wire        hold    = dm_act & pm_act &
                      (dm_addr[BLK_AW] == pm_addr[BLK_AW]);
wire        pm_go   = pm_act & ~hold;
wire        pmd_go  = pm_go & pmd_act;
wire        cmiss   = pmd_act & fetch_req_i & ~ic_hit;

assign fetch_ready_o = fetch_req_i & ~hold & ~cmiss;
assign exec_hold_o   = hold;
assign cache_hit_o   = pmd_act & fetch_req_i & ic_hit & ~hold;
assign instr_o       = instr;

// second half of a held instruction repeats no computation
wire [47:0] pe_instr = phase_reg ? {30'h0, instr[17:0]} : instr;

// ============================================================
// processing elements
wire [31:0] x_dm_st;
wire [31:0] x_pm_st;
wire [31:0] y_dm_st;
wire [31:0] y_pm_st;
wire [63:0] dm_wdata = {y_dm_st, x_dm_st};
wire [63:0] pm_wdata = {y_pm_st, x_pm_st};

sdp_pe u_first_processing_element (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .active_i     (1'b1),
    .alt_i        (alt_regs_i),
    .instr_i      (pe_instr),
    .dm_ld_i      (dm_ldv_reg),
    .dm_ld_reg_i  (dm_ldr_reg),
    .dm_ld_data_i (dm_rdata_reg[31:0]),
    .pm_ld_i      (pm_ldv_reg),
    .pm_ld_reg_i  (pm_ldr_reg),
    .pm_ld_data_i (pm_rdata_reg[31:0]),
    .dm_st_data_o (x_dm_st),
    .pm_st_data_o (x_pm_st)
);

sdp_pe u_second_processing_element (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .active_i     (simd),
    .alt_i        (alt_regs_i),
    .instr_i      (pe_instr),
    .dm_ld_i      (dm_ldv_reg),
    .dm_ld_reg_i  (dm_ldr_reg),
    .dm_ld_data_i (dm_rdata_reg[63:32]),
    .pm_ld_i      (pm_ldv_reg),
    .pm_ld_reg_i  (pm_ldr_reg),
    .pm_ld_data_i (pm_rdata_reg[63:32]),
    .dm_st_data_o (y_dm_st),
    .pm_st_data_o (y_pm_st)
);

// ============================================================
// memory write ports: io first so a core write to the same
// halfword in the same cycle lands last and wins
always @(posedge clock_i) begin
    for (lane = 0; lane < 4; lane = lane + 1) begin
        if (io_req_i & io_we_i & (lane <= io_size_i))
            mem[io_addr_i[BLK_AW]]
               [hadd(io_addr_i[BLK_AW-1:0], lane[1:0])]
               <= io_wdata_i[16*lane +: 16];
    end
    // core lanes after all io lanes, whatever lane offsets meet
    for (lane = 0; lane < 4; lane = lane + 1) begin
        if (dm_act & instr[`SDP_DM_WR] & (lane <= csz))
            mem[dm_addr[BLK_AW]]
               [hadd(dm_addr[BLK_AW-1:0], lane[1:0])]
               <= dm_wdata[16*lane +: 16];
        if (pmd_go & instr[`SDP_PM_WR] & (lane <= csz))
            mem[pm_addr[BLK_AW]]
               [hadd(pm_addr[BLK_AW-1:0], lane[1:0])]
               <= pm_wdata[16*lane +: 16];
    end
end

// cache lines fill one cycle after the retried fetch returns
always @(posedge clock_i) begin
    if (alloc_now_reg)
        ic_data_reg[alloc_addr_reg[CAW-1:0]] <= imem_reg;
end

// ============================================================
// reads, issue sequencing, cache tags and pointers
always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
        dm_rdata_reg   <= 64'h0;
        pm_rdata_reg   <= 64'h0;
        io_rdata_o     <= 64'h0;
        io_rvalid_o    <= 1'b0;
        dm_ldv_reg     <= 1'b0;
        pm_ldv_reg     <= 1'b0;
        dm_ldr_reg     <= 4'h0;
        pm_ldr_reg     <= 4'h0;
        imem_reg       <= 48'h0;
        icache_reg     <= 48'h0;
        isrc_reg       <= ISRC_NOP;
        phase_reg      <= 1'b0;
        alloc_pend_reg <= 1'b0;
        alloc_now_reg  <= 1'b0;
        alloc_addr_reg <= {(BLK_AW+1){1'b0}};
        ic_vld_reg     <= {NLINE{1'b0}};
        for (n = 0; n < NLINE; n = n + 1)
            ic_tag_reg[n] <= {(BLK_AW-CAW+1){1'b0}};
        for (n = 0; n < 32; n = n + 1) begin
            idx_reg[n]  <= {(BLK_AW+1){1'b0}};
            mod_reg[n]  <= {(BLK_AW+1){1'b0}};
            base_reg[n] <= {(BLK_AW+1){1'b0}};
            len_reg[n]  <= {(BLK_AW+1){1'b0}};
        end
    end else begin
        // three ports read in one cycle, unused lanes read zero
        for (k = 0; k < 4; k = k + 1) begin
            if (dm_act)
                dm_rdata_reg[16*k +: 16] <= (k <= csz) ?
                    mem[dm_addr[BLK_AW]]
                       [hadd(dm_addr[BLK_AW-1:0], k[1:0])]
                    : 16'h0000;
            if (pmd_go)
                pm_rdata_reg[16*k +: 16] <= (k <= csz) ?
                    mem[pm_addr[BLK_AW]]
                       [hadd(pm_addr[BLK_AW-1:0], k[1:0])]
                    : 16'h0000;
            if (io_req_i & ~io_we_i)
                io_rdata_o[16*k +: 16] <= (k <= io_size_i) ?
                    mem[io_addr_i[BLK_AW]]
                       [hadd(io_addr_i[BLK_AW-1:0], k[1:0])]
                    : 16'h0000;
        end
        io_rvalid_o <= io_req_i & ~io_we_i;
        dm_ldv_reg  <= dm_act & ~instr[`SDP_DM_WR];
        dm_ldr_reg  <= instr[`SDP_DM_REG];
        pm_ldv_reg  <= pmd_go & ~instr[`SDP_PM_WR];
        pm_ldr_reg  <= instr[`SDP_PM_REG];

        // instruction issue; a held instruction stays in place
        alloc_now_reg <= 1'b0;
        if (hold) begin
            phase_reg <= 1'b1;
        end else begin
            phase_reg <= 1'b0;
            if (fetch_ready_o & fetch_mem) begin
                for (k = 0; k < 3; k = k + 1)
                    imem_reg[16*k +: 16] <=
                        mem[fetch_addr_i[BLK_AW]]
                           [hadd(fetch_addr_i[BLK_AW-1:0], k[1:0])];
                isrc_reg       <= ISRC_MEM;
                // only a fetch that lost to data is kept
                alloc_now_reg  <= alloc_pend_reg;
                alloc_addr_reg <= fetch_addr_i;
                alloc_pend_reg <= 1'b0;
            end else if (fetch_ready_o) begin
                icache_reg <= ic_data_reg[line];
                isrc_reg   <= ISRC_CACHE;
            end else begin
                // a bubble frees the bus for the retried fetch
                isrc_reg       <= ISRC_NOP;
                alloc_pend_reg <= alloc_pend_reg | cmiss;
            end
        end
        if (alloc_now_reg) begin
            ic_vld_reg[alloc_addr_reg[CAW-1:0]] <= 1'b1;
            ic_tag_reg[alloc_addr_reg[CAW-1:0]] <=
                alloc_addr_reg[BLK_AW:CAW];
        end

        // pointer post-modify; an explicit load lands last
        if (dm_act)
            idx_reg[dset] <= circ(dm_addr, mod_reg[dset],
                base_reg[dset], len_reg[dset]);
        if (pmd_go)
            idx_reg[pset2] <= circ(pmd_addr, mod_reg[pset2],
                base_reg[pset2], len_reg[pset2]);
        if (ptr_wr_i) begin
            case (ptr_field_i)
            `SDP_PF_IDX:  idx_reg[ptr_set_i]  <= ptr_data_i;
            `SDP_PF_MOD:  mod_reg[ptr_set_i]  <= ptr_data_i;
            `SDP_PF_BASE: base_reg[ptr_set_i] <= ptr_data_i;
            default:      len_reg[ptr_set_i]  <= ptr_data_i;
            endcase
        end
    end
end

endmodule // sdp_core
`default_nettype wire

// ==== sdp_core_props.sv ====
// sdp_core_props.sv: timing checks on the ports of the core datapath
`timescale 1ns/1ps
`default_nettype none
module sdp_core_chk (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        fetch_req_i,
    input wire logic        fetch_ready_o,
    input wire logic        exec_hold_o,
    input wire logic        cache_hit_o,
    input wire logic [47:0] instr_o,
    input wire logic        io_req_i,
    input wire logic        io_we_i,
    input wire logic [1:0]  io_size_i,
    input wire logic [63:0] io_rdata_o,
    input wire logic        io_rvalid_o
);
    // ========
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    a_io_answer: assert property (
        io_rvalid_o == $past(io_req_i && !io_we_i))
        else $error("io read answer late or spurious");
    a_lane16_zero: assert property (
        io_rvalid_o && $past(io_size_i) == 2'h0 |-> io_rdata_o[63:16] == 48'h0)
        else $error("unused lanes of short read not zero");
    a_hold_refuses: assert property (
        exec_hold_o |-> !fetch_ready_o)
        else $error("fetch taken during hold");
    a_hold_once: assert property (
        exec_hold_o |=> !exec_hold_o)
        else $error("hold longer than one extra cycle");
    a_hold_stands: assert property (
        exec_hold_o |=> $stable(instr_o))
        else $error("instruction changed during hold");
    a_refused_nop: assert property (
        fetch_req_i && !fetch_ready_o && !exec_hold_o |=> instr_o == 48'h0)
        else $error("refused fetch did not give nop");
    a_hit_served: assert property (
        fetch_req_i && cache_hit_o |-> fetch_ready_o)
        else $error("cache hit not taken");
    a_free_fetch: assert property (
        fetch_req_i && !exec_hold_o && !instr_o[8] |-> fetch_ready_o)
        else $error("fetch refused without conflict");
    a_miss_refused: assert property (
        fetch_req_i && instr_o[8] && !exec_hold_o && !cache_hit_o
        |-> !fetch_ready_o)
        else $error("conflicting miss was taken");
endmodule // sdp_core_chk

bind sdp_core sdp_core_chk chk_u (
    .clock_i(clock_i), .nrst_i(nrst_i), .fetch_req_i(fetch_req_i),
    .fetch_ready_o(fetch_ready_o), .exec_hold_o(exec_hold_o),
    .cache_hit_o(cache_hit_o), .instr_o(instr_o), .io_req_i(io_req_i),
    .io_we_i(io_we_i), .io_size_i(io_size_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o));
`default_nettype wire

// ==== sdp_io_model.sv ====
// sdp_io_model.sv: io processor side of the memory io port
`timescale 1ns/1ps
`default_nettype none
module sdp_io_model (
    input  wire logic        clock_i,
    output var  logic        io_req_o,
    output var  logic        io_we_o,
    output var  logic [6:0]  io_addr_o,
    output var  logic [1:0]  io_size_o,
    output var  logic [63:0] io_wdata_o,
    input  wire logic [63:0] io_rdata_i
);
    // ========
    // idle port at time zero
    initial begin
        io_req_o = 1'b0;
        io_we_o = 1'b0;
        io_addr_o = 7'h00;
        io_size_o = 2'h0;
        io_wdata_o = 64'h0;
    end

    // one-cycle request; data sampled once the registered answer settles
    task xfer(input logic we, input logic [6:0] a, input logic [1:0] sz,
              input logic [63:0] wd, output logic [63:0] rd);
        begin
            @(posedge clock_i);
            io_req_o <= 1'b1;
            io_we_o <= we;
            io_addr_o <= a;
            io_size_o <= sz;
            io_wdata_o <= wd;
            @(posedge clock_i);
            // released lines show junk so a late sample cannot pass
            io_req_o <= 1'b0;
            io_addr_o <= ~a;
            io_wdata_o <= ~wd;
            @(negedge clock_i);
            rd = io_rdata_i;
        end
    endtask
endmodule // sdp_io_model
`default_nettype wire

// ==== testbench.sv ====
// testbench.sv: self-checking bench for the simd core datapath
`timescale 1ns/1ps
`default_nettype none
`include "sdp_consts.vh"
module testbench;
    localparam logic [6:0] PRG = 7'h40; // code in block 1, data in 0
    logic        clk, nrst, simd, alt, freq, pwr, sm, al;
    logic [6:0]  faddr, pdat, md;
    logic [4:0]  pset;
    logic [1:0]  pfld, sz;
    logic [3:0]  op;
    logic [31:0] a0, b0, a1, b1, e0, m0;
    logic [63:0] pat, rd, ex;
    logic [47:0] prog [0:6];
    wire         fready, hit, ioreq, iowe;
    wire  [6:0]  ioaddr;
    wire  [1:0]  iosz;
    wire  [63:0] iowd, iord;
    integer      bad_count, checked, hits, k, j, seed;

    // ========
    // small blocks keep the run short
    sdp_core #(.BLK_AW(6), .CAW(5)) dut_u (
        .clock_i(clk), .nrst_i(nrst), .second_element_enable_i(simd),
        .alt_regs_i(alt), .alt_ptrs_i(alt), .fetch_req_i(freq),
        .fetch_addr_i(faddr), .fetch_ready_o(fready), .exec_hold_o(),
        .cache_hit_o(hit), .instr_o(), .ptr_wr_i(pwr), .ptr_set_i(pset),
        .ptr_field_i(pfld), .ptr_data_i(pdat), .io_req_i(ioreq),
        .io_we_i(iowe), .io_addr_i(ioaddr), .io_size_i(iosz),
        .io_wdata_i(iowd), .io_rdata_o(iord), .io_rvalid_o());
    sdp_io_model io_u (
        .clock_i(clk), .io_req_o(ioreq), .io_we_o(iowe), .io_addr_o(ioaddr),
        .io_size_o(iosz), .io_wdata_o(iowd), .io_rdata_i(iord));

    // 250 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // cache hits seen on fetches
    always @(negedge clk) if (hit === 1'b1 && freq === 1'b1) hits = hits + 1;

    // ========
    task check(input logic [63:0] seen, input logic [63:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch at %0t: seen %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d, mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // strobe stays up between writes, dropped by the caller
    task wp(input logic [4:0] s, input logic [1:0] f, input logic [6:0] d);
        begin
            @(posedge clk);
            pwr <= 1'b1;
            pset <= s;
            pfld <= f;
            pdat <= d;
        end
    endtask

    // fetch the seven words, holding each address until taken or 20 retries pass
    task run;
        integer i, n;
        begin
            @(posedge clk);
            for (i = 0; i < 7; i = i + 1) begin
                freq <= 1'b1;
                faddr <= 7'(PRG + 3 * i);
                n = 0;
                @(negedge clk);
                while (fready !== 1'b1 && n < 20) begin
                    n = n + 1;
                    @(negedge clk);
                end
                // a fetch never taken is a failure, not a skip
                if (n == 20) bad_count = bad_count + 1;
                @(posedge clk);
            end
            freq <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask

    function automatic logic [31:0] alu(input logic [3:0] c,
                                        input logic [31:0] a, b);
        case (c)
            `SDP_OP_ADD: alu = a + b;
            `SDP_OP_SUB: alu = a - b;
            `SDP_OP_AND: alu = a & b;
            `SDP_OP_OR:  alu = a | b;
            `SDP_OP_XOR: alu = a ^ b;
            `SDP_OP_LSL: alu = a << b[4:0];
            `SDP_OP_LSR: alu = a >> b[4:0];
            default:     alu = $signed(a) >>> b[4:0];
        endcase
    endfunction

    // ========
    // watchdog well beyond the expected run length
    initial begin
        #40000;
        bad_count = bad_count + 1;
        wrap_up;
    end

    initial begin
        {nrst, simd, alt, freq, pwr, faddr, pset, pfld, pdat} = 0;
        bad_count = 0;
        checked = 0;
        hits = 0;
        seed = $urandom(32'h00d5);
        // ld r1, ld r2, dm and pm on block 0, nop, compute, st r3, st r4
        prog[0] = 48'h21000;
        prog[1] = 48'h22000;
        prog[2] = 48'h26328;
        prog[3] = `SDP_NOP;
        prog[5] = 48'h33000;
        prog[6] = 48'h34000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        pat = {$urandom, $urandom};
        io_u.xfer(1'b1, 7'd20, `SDP_SZ64, pat, rd);
        for (k = 0; k < 12; k = k + 1) begin
            op = (k < 10) ? 4'(k % 8 + 1) : 4'(k - 1);
            {a0, b0, a1, b1} = {$urandom, $urandom, $urandom, $urandom};
            if (k > 9) a0 = (k == 10) ? 32'h3f800000 : 32'h00003c00;
            if (k > 9) b0 = a0;
            sm = (k < 10) ? 1'($urandom) : 1'b0;
            al = 1'($urandom);
            md = sm ? 7'd4 : 7'd2;
            sz = sm ? `SDP_SZ64 : `SDP_SZ32;
            @(posedge clk);
            simd <= sm;
            alt <= al;
            io_u.xfer(1'b1, 7'd0, sz, {a1, a0}, rd);
            io_u.xfer(1'b1, md, sz, {b1, b0}, rd);
            wp({al, 4'h0}, `SDP_PF_IDX, 7'd0);
            wp({al, 4'h0}, `SDP_PF_MOD, md);
            wp({al, 4'h0}, `SDP_PF_BASE, 7'd0);
            wp({al, 4'h0}, `SDP_PF_LEN, 7'(3 * md));
            wp({al, 4'h8}, `SDP_PF_IDX, 7'd40);
            @(posedge clk);
            pwr <= 1'b0;
            prog[4] = {op, 12'h312, (k == 10) ? `SDP_MUL_FLT : `SDP_MUL_FIX,
                       12'h412, 18'h0};
            for (j = 0; j < 7; j = j + 1)
                io_u.xfer(1'b1, 7'(PRG + 3 * j), `SDP_SZ48,
                          {16'h0, prog[j]}, rd);
            // io traffic runs while the core executes
            fork
                run;
                begin
                    io_u.xfer(1'b0, 7'd20, `SDP_SZ64, 64'h0, rd);
                    check(rd, pat);
                end
            join
            e0 = (k == 10) ? 32'h3c00 : (k == 11) ? 32'h3f800000
                                                  : alu(op, a0, b0);
            m0 = (k == 10) ? 32'h3f800000 : a0 * b0;
            ex = sm ? {alu(op, a1, b1), e0} : {32'h0, e0};
            // a packed result is read as one halfword, upper lanes zero
            io_u.xfer(1'b0, 7'(2 * md), (k == 10) ? `SDP_SZ16 : sz, 64'h0, rd);
            check(rd, ex);
            io_u.xfer(1'b0, 7'd0, sz, 64'h0, rd);
            check(rd, sm ? {a1 * b1, m0} : {32'h0, m0});
        end
        check({63'h0, hits != 0}, 64'h1);
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
